/* File: rtl/psl_divider.sv */
// Module: programmable up-counting divider producing a one-cycle tick
`timescale 1ns/10ps
module psl_divider #(
   parameter int W = 14
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic step_i,
   input wire logic clear_i,
   input wire logic [W-1:0] ratio_i,
   output logic tick_o
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic tick;
   } psl_div_s;
   psl_div_s st_r;
   psl_div_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (clear_i) begin
         st_nxt.cnt = '0;
      end else if (step_i) begin
         // Ratio of zero treated as one
         if (st_r.cnt + W'(1) >= ratio_i) begin
            st_nxt.cnt = '0;
            st_nxt.tick = 1'b1;
         end else begin
            st_nxt.cnt = st_r.cnt + W'(1);
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_r <= '0;
      end else if (ce_i) begin
         st_r <= st_nxt;
      end
   end

   assign tick_o = st_r.tick;
endmodule // psl_divider

/* File: rtl/psl_latch_dividers.sv */
// Module: serial latch, reference and feedback dividers, lock detect, band select
// Overview of operation
// - Host sends MSB first; one bit shifts in per serial clock rise.
// - Load strobe rise copies the input register into a latch.
// - Select 00 config, 01 reference, 10 feedback, 11 test latch.
// - Reference divider is 14 bits, ratios 1 to 16383.
// - Main feedback counter is 13 bits, values 3 to 8191.
// - Swallow counter is 5 bits, values 0 to 31.
// - Total feedback division is modulus times main plus swallow.
// - Lock select zero: three good cycles under 15 ns set lock.
// - Lock select one: five good cycles under 15 ns set lock.
// - Lock holds until a cycle shows error above 25 ns or a feedback word is loaded.
// - Analog lock on monitor: released high with short low pulses while locked, held low while unlocked.
// - Monitor select bits 7 to 5 choose the monitor source.
// - Band select starts at power-up and each feedback word load.
// - Band select lasts five detector cycles with tuning on reference voltage.
// - Band clock divider of 1, 2, 4 or 8 precedes reference counter.
// - Mute bit keeps RF output supply off until digital lock.
// - Halve bit 22 in feedback word enables output divide by two.
// - Configuration and feedback word fields sit at their fixed positions.
`timescale 1ns/10ps
module psl_latch_dividers
   import psl_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic serial_clk_i,
   input wire logic serial_data_i,
   input wire logic load_strobe_i,
   input wire logic ref_in_i,
   input wire logic prescaler_out_i,
   input wire logic prescaler_mod_i,
   output logic [WORD_W-1:0] loop_configuration_word_o,
   output logic [WORD_W-1:0] reference_divider_word_o,
   output logic [WORD_W-1:0] feedback_divider_word_o,
   output logic ref_clk_o,
   output logic fb_clk_o,
   output logic modulus_ctrl_o,
   output logic lock_o,
   output logic band_select_o,
   output logic tune_to_ref_o,
   output logic rf_supply_en_o,
   output logic halve_output_o,
   output logic monitor_output_o,
   output logic monitor_output_oe_o
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef enum logic [1:0] {BAND_IDLE, BAND_RUN} psl_band_e;
   typedef struct packed {
      logic [2:0] sclk_sync;
      logic [1:0] sdat_sync;
      logic [2:0] le_sync;
      logic [2:0] ref_sync;
      logic [2:0] pre_sync;
      logic [WORD_W-1:0] shift;
      logic [WORD_W-1:0] cfg;
      logic [WORD_W-1:0] refw;
      logic [WORD_W-1:0] fbw;
      logic [WORD_W-1:0] test;
      logic [2:0] band_pre;
      logic [FB_SWAL_W-1:0] swal_cnt;
      logic [FB_MAIN_W-1:0] main_cnt;
      logic fb_tick;
      logic in_swallow;
      logic ref_pend;
      logic fb_pend;
      logic [3:0] err_cnt;
      logic [2:0] good_cnt;
      logic lock;
      psl_band_e band;
      logic [2:0] band_cnt;
      logic band_start;
      logic ref_clk;
      logic fb_clk;
      logic [1:0] alock_pulse;
      logic mon;
      logic mon_oe;
      logic rf_en;
   } psl_state_s;
   psl_state_s st_r;
   psl_state_s st_nxt;

   logic ref_step;
   logic ref_tick;
   logic sclk_rise;
   logic le_rise;
   logic ref_rise;
   logic pre_rise;
   logic clear_cnt;
   logic [3:0] band_ratio;
   logic [2:0] mon_sel;
   logic [2:0] lock_need;
   logic fb_reload;
   logic mon_val;
   logic mon_drive;

   assign sclk_rise = st_r.sclk_sync[1] & ~st_r.sclk_sync[2];
   assign le_rise = st_r.le_sync[1] & ~st_r.le_sync[2];
   assign ref_rise = st_r.ref_sync[1] & ~st_r.ref_sync[2];
   assign pre_rise = st_r.pre_sync[1] & ~st_r.pre_sync[2];
   assign clear_cnt = st_r.cfg[CFG_CLEAR];
   assign mon_sel = st_r.cfg[CFG_MON_HI:CFG_MON_LO];

   // ------------------------------------------------------------
   // Band clock prescale and reference divider
   // ------------------------------------------------------------
   always_comb begin
      case (st_r.refw[REF_BAND_HI:REF_BAND_LO])
         2'h0: band_ratio = 4'h1;
         2'h1: band_ratio = 4'h2;
         2'h2: band_ratio = 4'h4;
         default: band_ratio = 4'h8;
      endcase
   end
   assign ref_step = ref_rise && ((st_r.band_pre + 3'h1) == band_ratio[2:0] || band_ratio == 4'h8
                     && st_r.band_pre == 3'h7 || band_ratio == 4'h1);

   psl_divider #(
      .W(REF_DIV_W)
   ) u_ref_div (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .step_i(ref_step),
      .clear_i(clear_cnt),
      .ratio_i(st_r.refw[REF_DIV_HI:REF_DIV_LO]),
      .tick_o(ref_tick)
   );

   assign lock_need = st_r.refw[REF_LOCK_CNT] ? LOCK_CNT_LONG : LOCK_CNT_SHORT;
   assign fb_reload = (st_r.main_cnt <= FB_MAIN_W'(1));

   always_comb begin
      case (mon_sel)
         MON_TRISTATE: begin
            mon_val = 1'b0;
            mon_drive = 1'b0;
         end
         MON_DLOCK: begin
            mon_val = st_r.lock;
            mon_drive = 1'b1;
         end
         MON_FB_DIV: begin
            mon_val = st_r.fb_clk;
            mon_drive = 1'b1;
         end
         MON_HIGH: begin
            mon_val = 1'b1;
            mon_drive = 1'b1;
         end
         MON_REF_DIV: begin
            mon_val = st_r.ref_clk;
            mon_drive = 1'b1;
         end
         MON_DATA: begin
            mon_val = st_r.sdat_sync[1];
            mon_drive = 1'b1;
         end
         MON_ALOCK: begin
            // Open drain: only pulls low, released to the pull-up otherwise
            mon_val = 1'b0;
            mon_drive = !st_r.lock || st_r.alock_pulse != 2'h0;
         end
         default: begin
            mon_val = 1'b0;
            mon_drive = 1'b1;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.sclk_sync = {st_r.sclk_sync[1:0], serial_clk_i};
      st_nxt.sdat_sync = {st_r.sdat_sync[0], serial_data_i};
      st_nxt.le_sync = {st_r.le_sync[1:0], load_strobe_i};
      st_nxt.ref_sync = {st_r.ref_sync[1:0], ref_in_i};
      st_nxt.pre_sync = {st_r.pre_sync[1:0], prescaler_out_i};
      st_nxt.band_start = 1'b0;
      st_nxt.fb_tick = 1'b0;

      // Serial shift, MSB first; data pairs with the synced clock edge
      if (sclk_rise) begin
         st_nxt.shift = {st_r.shift[WORD_W-2:0], st_r.sdat_sync[1]};
      end
      if (le_rise) begin
         case (st_r.shift[1:0])
            SEL_CONFIG: st_nxt.cfg = st_r.shift;
            SEL_REF: st_nxt.refw = st_r.shift;
            SEL_FEEDBACK: begin
               st_nxt.fbw = st_r.shift;
               st_nxt.band_start = 1'b1;
            end
            default: st_nxt.test = st_r.shift;
         endcase
      end

      // Band clock prescale
      if (ref_rise) begin
         st_nxt.band_pre = ref_step ? 3'h0 : st_r.band_pre + 3'h1;
      end

      // Feedback counter: swallow phase at P+1, then main at P
      if (clear_cnt) begin
         st_nxt.main_cnt = st_r.fbw[FB_MAIN_HI:FB_MAIN_LO];
         st_nxt.swal_cnt = st_r.fbw[FB_SWAL_HI:FB_SWAL_LO];
         st_nxt.in_swallow = (st_r.fbw[FB_SWAL_HI:FB_SWAL_LO] != '0);
      end else if (pre_rise) begin
         if (fb_reload) begin
            st_nxt.main_cnt = st_r.fbw[FB_MAIN_HI:FB_MAIN_LO];
            st_nxt.swal_cnt = st_r.fbw[FB_SWAL_HI:FB_SWAL_LO];
            st_nxt.in_swallow = (st_r.fbw[FB_SWAL_HI:FB_SWAL_LO] != '0);
            st_nxt.fb_tick = 1'b1;
         end else begin
            st_nxt.main_cnt = st_r.main_cnt - FB_MAIN_W'(1);
            if (st_r.swal_cnt != '0) begin
               st_nxt.swal_cnt = st_r.swal_cnt - FB_SWAL_W'(1);
            end
            if (st_r.swal_cnt <= FB_SWAL_W'(1)) begin
               st_nxt.in_swallow = 1'b0;
            end
         end
      end
      if (st_r.fbw[FB_SWAL_HI:FB_SWAL_LO] == '0 && !fb_reload) begin
         st_nxt.in_swallow = 1'b0;
      end

      // Half-rate square waves for the monitor
      if (ref_tick) begin
         st_nxt.ref_clk = ~st_r.ref_clk;
      end
      if (st_r.fb_tick) begin
         st_nxt.fb_clk = ~st_r.fb_clk;
      end

      // Phase error window between reference and feedback edges
      if (ref_tick && st_r.fb_tick) begin
         st_nxt.err_cnt = 4'h0;
         st_nxt.ref_pend = 1'b0;
         st_nxt.fb_pend = 1'b0;
      end else if (ref_tick || st_r.fb_tick) begin
         if (st_r.ref_pend || st_r.fb_pend) begin
            st_nxt.ref_pend = 1'b0;
            st_nxt.fb_pend = 1'b0;
         end else begin
            st_nxt.ref_pend = ref_tick;
            st_nxt.fb_pend = st_r.fb_tick;
            st_nxt.err_cnt = 4'h1;
         end
      end else if ((st_r.ref_pend || st_r.fb_pend) && st_r.err_cnt != 4'hF) begin
         st_nxt.err_cnt = st_r.err_cnt + 4'h1;
      end

      // Lock judged on each reference tick; a feedback load or an overdue feedback edge clears it in any cycle
      if (ref_tick) begin
         st_nxt.alock_pulse = 2'h2;
         if (st_r.ref_pend || st_r.fb_pend) begin
            if (st_r.err_cnt > LOCK_LOSE_CYC) begin
               st_nxt.lock = 1'b0;
               st_nxt.good_cnt = 3'h0;
            end
         end else if (st_r.fb_tick || st_r.err_cnt < LOCK_SET_CYC) begin
            if (st_r.good_cnt + 3'h1 >= lock_need) begin
               st_nxt.lock = 1'b1;
            end else begin
               st_nxt.good_cnt = st_r.good_cnt + 3'h1;
            end
         end else begin
            st_nxt.good_cnt = 3'h0;
         end
      end else if (st_r.alock_pulse != 2'h0) begin
         st_nxt.alock_pulse = st_r.alock_pulse - 2'h1;
      end
      if (st_r.band_start || (st_r.ref_pend && st_r.err_cnt > LOCK_LOSE_CYC)) begin
         st_nxt.lock = 1'b0;
         st_nxt.good_cnt = 3'h0;
      end

      // Band select: five detector cycles on reference voltage
      case (st_r.band)
         BAND_IDLE: begin
            if (st_r.band_start) begin
               st_nxt.band = BAND_RUN;
               st_nxt.band_cnt = 3'h0;
            end
         end
         BAND_RUN: begin
            if (st_r.band_start) begin
               st_nxt.band_cnt = 3'h0;
            end else if (ref_tick) begin
               if (st_r.band_cnt + 3'h1 >= BAND_CYCLES) begin
                  st_nxt.band = BAND_IDLE;
               end else begin
                  st_nxt.band_cnt = st_r.band_cnt + 3'h1;
               end
            end
         end
         default: st_nxt.band = BAND_IDLE;
      endcase

      st_nxt.mon = mon_val;
      st_nxt.mon_oe = mon_drive;
      st_nxt.rf_en = !st_r.cfg[CFG_MUTE] || st_r.lock;
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_r <= '0;
         st_r.band <= BAND_RUN;
      end else if (ce_i) begin
         st_r <= st_nxt;
      end
   end

   // Modulus control follows the prescaler count and the counter clear; it settles before its next edge
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         modulus_ctrl_o <= 1'b0;
         halve_output_o <= 1'b0;
         band_select_o <= 1'b0;
      end else if (ce_i) begin
         modulus_ctrl_o <= st_nxt.in_swallow;
         halve_output_o <= st_nxt.fbw[FB_HALVE];
         band_select_o <= (st_nxt.band == BAND_RUN);
      end
   end

   assign loop_configuration_word_o = st_r.cfg;
   assign reference_divider_word_o = st_r.refw;
   assign feedback_divider_word_o = st_r.fbw;
   assign ref_clk_o = st_r.ref_clk;
   assign fb_clk_o = st_r.fb_clk;
   assign lock_o = st_r.lock;
   assign tune_to_ref_o = band_select_o;
   assign rf_supply_en_o = st_r.rf_en;
   assign monitor_output_o = st_r.mon;
   assign monitor_output_oe_o = st_r.mon_oe;
endmodule // psl_latch_dividers

/* File: rtl/psl_pkg.sv */
// Package: constants for the synthesizer serial latch and divider block
package psl_pkg;
   // ------------------------------------------------------------
   // Word layout
   // ------------------------------------------------------------
   localparam int WORD_W = 24;
   localparam logic [1:0] SEL_CONFIG = 2'h0;
   localparam logic [1:0] SEL_REF = 2'h1;
   localparam logic [1:0] SEL_FEEDBACK = 2'h2;
   localparam logic [1:0] SEL_TEST = 2'h3;
   // Configuration word fields
   localparam int CFG_MODULUS_HI = 23;
   localparam int CFG_MODULUS_LO = 22;
   localparam int CFG_PD_SYNC = 21;
   localparam int CFG_PD_REQ = 20;
   localparam int CFG_PUMP_HI = 19;
   localparam int CFG_PUMP_LO = 14;
   localparam int CFG_DRIVE_HI = 13;
   localparam int CFG_DRIVE_LO = 12;
   localparam int CFG_MUTE = 11;
   localparam int CFG_PUMP_GAIN = 10;
   localparam int CFG_TRISTATE = 9;
   localparam int CFG_POLARITY = 8;
   localparam int CFG_MON_HI = 7;
   localparam int CFG_MON_LO = 5;
   localparam int CFG_CLEAR = 4;
   localparam int CFG_CORE_HI = 3;
   localparam int CFG_CORE_LO = 2;
   // Reference word fields
   localparam int REF_BAND_HI = 21;
   localparam int REF_BAND_LO = 20;
   localparam int REF_LOCK_CNT = 18;
   localparam int REF_DIV_HI = 15;
   localparam int REF_DIV_LO = 2;
   localparam int REF_DIV_W = 14;
   // Feedback word fields
   localparam int FB_ROUTE = 23;
   localparam int FB_HALVE = 22;
   localparam int FB_GAIN = 21;
   localparam int FB_MAIN_HI = 20;
   localparam int FB_MAIN_LO = 8;
   localparam int FB_MAIN_W = 13;
   localparam int FB_SWAL_HI = 6;
   localparam int FB_SWAL_LO = 2;
   localparam int FB_SWAL_W = 5;
   // ------------------------------------------------------------
   // Lock detect and band select
   // ------------------------------------------------------------
   localparam int LOCK_SET_NS = 15;
   localparam int LOCK_LOSE_NS = 25;
   localparam int CLK_NS = 20;
   // Phase error counted in sys_clk cycles; set and loss both round up
   localparam logic [3:0] LOCK_SET_CYC = 4'((LOCK_SET_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] LOCK_LOSE_CYC = 4'((LOCK_LOSE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [2:0] LOCK_CNT_SHORT = 3'h3;
   localparam logic [2:0] LOCK_CNT_LONG = 3'h5;
   localparam logic [2:0] BAND_CYCLES = 3'h5;
   // Monitor select codes
   localparam logic [2:0] MON_TRISTATE = 3'h0;
   localparam logic [2:0] MON_DLOCK = 3'h1;
   localparam logic [2:0] MON_FB_DIV = 3'h2;
   localparam logic [2:0] MON_HIGH = 3'h3;
   localparam logic [2:0] MON_REF_DIV = 3'h4;
   localparam logic [2:0] MON_DATA = 3'h5;
   localparam logic [2:0] MON_ALOCK = 3'h6;
   localparam logic [2:0] MON_LOW = 3'h7;
endpackage

/* File: testbench/psl_host_model.sv */
// Host model: drives the three-wire serial link of the latch block
`timescale 1ns/10ps
module psl_host_model (
   input wire logic sys_clk_i,
   output logic serial_clk_o,
   output logic serial_data_o,
   output logic load_strobe_o
);
   initial begin
      serial_clk_o = 1'b0;
      serial_data_o = 1'b0;
      load_strobe_o = 1'b0;
   end
   // ------------------------------------------------------------
   // Word transfer
   // ------------------------------------------------------------
   // Four sys clocks per phase keeps clear of the 3-cycle minimum
   task automatic send(input logic [23:0] word, input logic load);
      for (int i = 23; i >= 0; i--) begin
         serial_data_o = word[i];
         repeat (4) @(negedge sys_clk_i);
         serial_clk_o = 1'b1;
         repeat (4) @(negedge sys_clk_i);
         serial_clk_o = 1'b0;
      end
      // Released line shows the inverse so a stale bit cannot pass
      serial_data_o = ~word[0];
      repeat (4) @(negedge sys_clk_i);
      if (load) begin
         load_strobe_o = 1'b1;
         repeat (4) @(negedge sys_clk_i);
         load_strobe_o = 1'b0;
         repeat (4) @(negedge sys_clk_i);
      end
   endtask
endmodule // psl_host_model

/* File: testbench/psl_latch_dividers_assertions.sv */
// Checker: concurrent assertions on the latch and divider block ports
`timescale 1ns/10ps
module psl_latch_dividers_assertions
   import psl_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic serial_clk_i,
   input wire logic serial_data_i,
   input wire logic load_strobe_i,
   input wire logic [WORD_W-1:0] loop_configuration_word_o,
   input wire logic [WORD_W-1:0] reference_divider_word_o,
   input wire logic [WORD_W-1:0] feedback_divider_word_o,
   input wire logic ref_clk_o,
   input wire logic lock_o,
   input wire logic band_select_o,
   input wire logic tune_to_ref_o,
   input wire logic rf_supply_en_o,
   input wire logic halve_output_o,
   input wire logic monitor_output_o,
   input wire logic monitor_output_oe_o
);
   // ------------------------------------------------------------
   // Helper state
   // ------------------------------------------------------------
   logic [23:0] sh_r;
   logic sclk_r;
   logic rclk_r;
   logic [7:0] bt_r;
   logic [7:0] tk_r;
   logic [2:0] msel;
   logic le_r;
   logic fb_ld;
   assign msel = loop_configuration_word_o[CFG_MON_HI:CFG_MON_LO];
   // A feedback load restarts band select and lock counting
   assign fb_ld = load_strobe_i && !le_r && sh_r[1:0] == SEL_FEEDBACK;
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sh_r <= 24'h000000;
         sclk_r <= 1'b0;
         rclk_r <= 1'b0;
         bt_r <= 8'h00;
         tk_r <= 8'h00;
         le_r <= 1'b0;
      end else begin
         le_r <= load_strobe_i;
         sclk_r <= serial_clk_i;
         rclk_r <= ref_clk_o;
         if (serial_clk_i && !sclk_r) begin
            sh_r <= {sh_r[22:0], serial_data_i};
         end
         bt_r <= (!band_select_o || fb_ld) ? 8'h00 : bt_r + 8'(ref_clk_o != rclk_r);
         tk_r <= fb_ld ? 8'h00 : (tk_r == 8'hFF ? tk_r : tk_r + 8'(ref_clk_o != rclk_r));
      end
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_load(logic [1:0] sel);
      $rose(load_strobe_i) && sh_r[1:0] == sel;
   endsequence
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   a_cfg_load_word: assert property (s_load(SEL_CONFIG) |-> ##[3:5] loop_configuration_word_o == sh_r)
      else $error("config word not loaded");
   a_ref_load_word: assert property (s_load(SEL_REF) |-> ##[3:5] reference_divider_word_o == sh_r)
      else $error("reference word not loaded");
   a_fb_load_word: assert property (s_load(SEL_FEEDBACK) |-> ##[3:5] feedback_divider_word_o == sh_r)
      else $error("feedback word not loaded");
   a_test_latch_inert: assert property (s_load(SEL_TEST) |=> ($stable(loop_configuration_word_o)
      && $stable(reference_divider_word_o) && $stable(feedback_divider_word_o)) [*6])
      else $error("test latch write changed a word");
   a_band_on_load: assert property (s_load(SEL_FEEDBACK) |-> ##[4:8] band_select_o)
      else $error("band select did not start");
   a_band_five_ticks: assert property ($fell(band_select_o) |-> bt_r inside {[8'h04:8'h05]})
      else $error("band select length wrong");
   a_tune_follows_band: assert property (tune_to_ref_o == band_select_o)
      else $error("tuning switch differs from band select");
   a_lock_needs_count: assert property ($rose(lock_o)
      |-> tk_r >= (reference_divider_word_o[REF_LOCK_CNT] ? 8'h04 : 8'h02))
      else $error("lock set too early");
   a_mute_keeps_off: assert property (loop_configuration_word_o[CFG_MUTE] && !lock_o && !$past(lock_o)
      && $stable(loop_configuration_word_o) |-> !rf_supply_en_o)
      else $error("supply on while muted and unlocked");
   a_halve_tracks_bit: assert property ($stable(feedback_divider_word_o)
      |-> halve_output_o == feedback_divider_word_o[FB_HALVE])
      else $error("halve output differs from word");
   a_monitor_low: assert property ($stable(loop_configuration_word_o) && msel == MON_LOW
      |-> monitor_output_oe_o && !monitor_output_o)
      else $error("monitor not driven low");
endmodule // psl_latch_dividers_assertions

/* File: testbench/test_psl_latch_dividers.sv */
// Testbench: serial loads, divider periods, lock, mute and monitor select
`timescale 1ns/10ps
module test_psl_latch_dividers
   import psl_pkg::*;
;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic sclk, sdata, strobe, slow = 1'b0;
   logic ref_in = 1'b0, psc = 1'b0;
   logic [23:0] cfg, rfw, fbw;
   logic ref_clk, fb_clk, modc, lock, band, tune, rfen, halve, mon, mon_oe, mon_w;
   int c = 0;
   int checked = 0;
   int n_fail = 0;
   integer seed = 32'h1EB2BD3C;
   assign mon_w = mon_oe ? mon : 1'b1;
   always #10 clk = ~clk;
   always @(negedge clk) begin
      c <= c + 1;
      ref_in <= c[1];
      psc <= slow ? (c % 6 >= 3) : c[1];
   end
   psl_host_model host_u (.sys_clk_i(clk), .serial_clk_o(sclk), .serial_data_o(sdata), .load_strobe_o(strobe));
   psl_latch_dividers dut_u (.sys_clk_i(clk), .nrst_i(nrst), .ce_i(1'b1), .serial_clk_i(sclk),
      .serial_data_i(sdata), .load_strobe_i(strobe), .ref_in_i(ref_in), .prescaler_out_i(psc),
      .prescaler_mod_i(1'b0), .loop_configuration_word_o(cfg), .reference_divider_word_o(rfw),
      .feedback_divider_word_o(fbw), .ref_clk_o(ref_clk), .fb_clk_o(fb_clk), .modulus_ctrl_o(modc),
      .lock_o(lock), .band_select_o(band), .tune_to_ref_o(tune), .rf_supply_en_o(rfen),
      .halve_output_o(halve), .monitor_output_o(mon), .monitor_output_oe_o(mon_oe));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [23:0] cfg_w(input logic [2:0] m, input logic mute, input logic clr);
      return (24'($random(seed)) & 24'hCFF70C) | {12'h000, mute, 3'h0, m, clr, 4'h0};
   endfunction
   function automatic logic [23:0] ref_w(input logic [13:0] r, input logic lock_count_select);
      return {5'h00, lock_count_select, 2'h0, r, 2'h1};
   endfunction
   function automatic logic [23:0] fb_w(input logic [12:0] b, input logic [4:0] a, input logic h);
      logic [1:0] rb;
      rb = 2'($random(seed));
      return {rb[1], h, rb[0], b, 1'b0, a, 2'h2};
   endfunction
   task automatic chkw(input logic [23:0] got, input logic [23:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chkb(input logic got, input logic exp);
      chkw({23'h0, got}, {23'h0, exp});
   endtask
   task automatic ld(input logic [23:0] w);
      host_u.send(w, 1'b1);
   endtask
   task automatic until_lock(input logic v);
      int n;
      n = 0;
      while (lock !== v && n < 3000) begin
         @(negedge clk);
         n++;
      end
      chkb(lock, v);
   endtask
   // One full interval between toggles, with modulus-high cycles in it
   task automatic meas(input logic fb, output int cyc, output int hi);
      logic p;
      cyc = 0;
      hi = 0;
      p = fb ? fb_clk : ref_clk;
      while ((fb ? fb_clk : ref_clk) === p && cyc < 9999) begin
         @(negedge clk);
         cyc++;
      end
      p = ~p;
      cyc = 0;
      while ((fb ? fb_clk : ref_clk) === p && cyc < 9999) begin
         @(negedge clk);
         cyc++;
         hi += (modc === 1'b1);
      end
   endtask
   task automatic results;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      int r, b, a, n, h;
      logic [23:0] wc, wr, wf;
      repeat (12) @(negedge clk);
      nrst = 1'b1;
      repeat (2) @(negedge clk);
      chkb(band, 1'b1);
      chkb(tune, 1'b1);
      for (int k = 0; k < 4; k++) begin
         r = (k == 0) ? 1 : 1 + {$random(seed)} % 40;
         b = (k == 0) ? 3 : (k == 1) ? 35 : 3 + {$random(seed)} % 30;
         a = (k == 0) ? 0 : (k == 1) ? 31 : {$random(seed)} % b;
         wr = ref_w(14'(r), 1'b0) | (24'(k) << REF_BAND_LO);
         ld(wr);
         chkw(rfw, wr);
         wc = cfg_w(MON_TRISTATE, 1'b0, 1'b1);
         ld(wc);
         chkw(cfg, wc);
         wf = fb_w(13'(b), 5'(a), k[0]);
         host_u.send(24'($random(seed)), 1'b0);
         ld(wf);
         chkw(fbw, wf);
         chkb(halve, k[0]);
         chkb(band, 1'b1);
         chkb(tune, 1'b1);
         // Refused write: the hidden latch must leave every word alone
         ld({22'($random(seed)), SEL_TEST});
         chkw(cfg, wc);
         chkw(rfw, wr);
         chkw(fbw, wf);
         ld(cfg_w(MON_TRISTATE, 1'b0, 1'b0));
         meas(1'b0, n, h);
         chkw(24'(n), 24'(r * 4 << k));
         meas(1'b1, n, h);
         chkw(24'(n), 24'(b * 4));
         chkw(24'(h), 24'(a * 4));
      end
      $display("test dividers done");
      for (int k = 0; k < 2; k++) begin
         slow = 1'b0;
         ld(ref_w(14'h0005, k[0]));
         ld(cfg_w(MON_DLOCK, 1'b1, 1'b1));
         ld(fb_w(13'h0005, 5'h01, 1'b0));
         chkb(rfen, 1'b0);
         ld(cfg_w(MON_DLOCK, 1'b1, 1'b0));
         until_lock(1'b1);
         repeat (2) @(negedge clk);
         chkb(rfen, 1'b1);
         h = 0;
         repeat (300) begin
            @(negedge clk);
            h += (lock === 1'b1);
         end
         chkw(24'(h), 24'h00012C);
         for (int m = 0; m < 8; m++) begin
            ld(cfg_w(3'(m), 1'b1, 1'b0));
            h = 0;
            repeat (64) begin
               @(negedge clk);
               h += (mon_w === 1'b1);
            end
            if (m == 0 || m == 1 || m == 3 || m == 5) chkw(24'(h), 24'h000040);
            if (m == 2 || m == 4) chkb(h > 16 && h < 48, 1'b1);
            if (m == 7) chkw(24'(h), 24'h000000);
            if (m == 0) chkb(mon_oe, 1'b0);
            if (m == 6) chkb(h >= 48, 1'b1);
         end
         // Slower feedback opens a growing phase error
         slow = 1'b1;
         until_lock(1'b0);
      end
      $display("test lock done");
      results();
   end
   initial begin
      repeat (60000) @(posedge clk);
      n_fail++;
      results();
   end
endmodule // test_psl_latch_dividers
bind psl_latch_dividers psl_latch_dividers_assertions chk_u (.sys_clk_i, .nrst_i, .serial_clk_i, .serial_data_i,
   .load_strobe_i, .loop_configuration_word_o, .reference_divider_word_o, .feedback_divider_word_o, .ref_clk_o,
   .lock_o, .band_select_o, .tune_to_ref_o, .rf_supply_en_o, .halve_output_o, .monitor_output_o,
   .monitor_output_oe_o);
